// >>> hdl/geom_pkg.sv
package geom_pkg;

  localparam int SENSOR_W  = 1608;
  localparam int SENSOR_H  = 1104;
  localparam int PIX_W     = 16;
  localparam int DIM_W     = 11;
  localparam int FACT_W    = 3;

  // Format code: bit 1 marks a mosaic, bit 0 marks 16-bit depth
  localparam int FMT_MOSAIC_BIT = 1;
  localparam int FMT_DEEP_BIT   = 0;
  localparam logic [1:0] FMT_MONO8   = 2'h0;
  localparam logic [1:0] FMT_MONO16  = 2'h1;
  localparam logic [1:0] FMT_MOSAIC8 = 2'h2;
  localparam logic [1:0] FMT_MOSAIC16 = 2'h3;

  // Mosaic phase: bit 1 is the row swap, bit 0 the column swap
  localparam int MOSAIC_ROW_BIT = 1;
  localparam int MOSAIC_COL_BIT = 0;
  localparam logic [1:0] MOSAIC_RED_GREEN  = 2'h0;
  localparam logic [1:0] MOSAIC_GREEN_RED  = 2'h1;
  localparam logic [1:0] MOSAIC_GREEN_BLUE = 2'h2;
  localparam logic [1:0] MOSAIC_BLUE_GREEN = 2'h3;

  // Filter report: top bit set when a filter exists
  localparam logic [2:0] FILTER_NONE = 3'h0;
  localparam logic [2:0] FILTER_SOME = 3'h4;

  localparam logic [4:0] BITS_SHALLOW = 5'h08;
  localparam logic [4:0] BITS_DEEP    = 5'h10;
  localparam logic [15:0] DYN_MIN      = 16'h0000;
  localparam logic [15:0] DYN_MAX_8    = 16'h00FF;
  localparam logic [15:0] DYN_MAX_16   = 16'hFFFF;
  localparam logic [15:0] SHALLOW_MASK = 16'hFF00;

  localparam logic [2:0] FACTOR_ONE   = 3'h1;
  localparam logic [1:0] FMT_RESET    = FMT_MONO8;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CAPT = 5'h02,
    ST_READ = 5'h04,
    ST_ACC  = 5'h08,
    ST_SEND = 5'h10
  } geom_state_e;

endpackage : geom_pkg

// >>> hdl/image_geometry_pipeline.sv
`timescale 1ns/100ps
`default_nettype none
module image_geometry_pipeline
  import geom_pkg::*;
#(
  parameter int SENS_W = SENSOR_W,
  parameter int SENS_H = SENSOR_H,
  parameter logic [1:0] MOSAIC_BASE = MOSAIC_RED_GREEN
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Sensor stream, no back-pressure
  input  wire logic              in_valid,
  input  wire logic              in_sof,
  input  wire logic [PIX_W-1:0]  in_data,
  output logic                   in_ready,
  // Host stream
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [PIX_W-1:0]       out_data,
  output logic                   out_sof,
  output logic                   out_eol,
  output logic                   out_eof,
  // Settings
  input  wire logic              col_flip,
  input  wire logic              row_flip,
  input  wire logic [DIM_W-1:0]  roi_col_offset,
  input  wire logic [DIM_W-1:0]  roi_row_offset,
  input  wire logic [DIM_W-1:0]  roi_width,
  input  wire logic [DIM_W-1:0]  roi_height,
  input  wire logic [1:0]        pixel_format,
  input  wire logic              proc_core_enable,
  input  wire logic              mono_request,
  input  wire logic              bin_sel,
  input  wire logic              bin_write,
  input  wire logic [FACT_W-1:0] col_bin_factor,
  input  wire logic [FACT_W-1:0] row_bin_factor,
  input  wire logic              skip_sel,
  input  wire logic              skip_write,
  input  wire logic [FACT_W-1:0] col_skip_factor,
  input  wire logic [FACT_W-1:0] row_skip_factor,
  // Read-only reports
  output logic [DIM_W-1:0]       sensor_width,
  output logic [DIM_W-1:0]       sensor_height,
  output logic [DIM_W-1:0]       max_image_width,
  output logic [DIM_W-1:0]       max_image_height,
  output logic [1:0]             reported_format,
  output logic [2:0]             pixel_filter,
  output logic [4:0]             pixel_size_bits,
  output logic [PIX_W-1:0]       dyn_range_min,
  output logic [PIX_W-1:0]       dyn_range_max
);

  // Whole frame stored: a row flip needs the last line first
  localparam int DEPTH  = SENS_W * SENS_H;
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int PROD_W = 2 * FACT_W;
  localparam int ACC_W  = PIX_W + 2 * PROD_W;
  localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);
  localparam logic [DIM_W-1:0]  SW_C      = DIM_W'(SENS_W);
  localparam logic [DIM_W-1:0]  SH_C      = DIM_W'(SENS_H);

  typedef struct packed {
    geom_state_e               state;
    logic [ADDR_W-1:0]         wr_addr;
    logic [FACT_W-1:0]         bin_c0, bin_c1, bin_r0, bin_r1;
    logic [FACT_W-1:0]         skip_c0, skip_c1, skip_r0, skip_r1;
    logic                      hflip, vflip;
    logic [DIM_W-1:0]          offx, offy, w, h;
    logic [DIM_W-1:0]          maxw, maxh;
    logic [PROD_W-1:0]         cells_c, cells_r, step_c, step_r;
    logic [1:0]                fmt;
    logic [DIM_W-1:0]          ox, oy;
    logic [PROD_W-1:0]         kc, kr;
    logic [ACC_W-1:0]          acc;
    logic                      o_valid, o_sof, o_eol, o_eof;
    logic [PIX_W-1:0]          o_data;
    logic [2:0]                filt;
    logic [4:0]                bits;
    logic [PIX_W-1:0]          dmax;
  } geom_s;

  geom_s s_r, s_nxt;

  logic [PIX_W-1:0]  frame_mem [DEPTH];
  logic [PIX_W-1:0]  rd_q;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [ADDR_W-1:0] mem_raddr;

  // Factor 0 is meaningless, so it counts as 1
  function automatic logic [FACT_W-1:0] nz(input logic [FACT_W-1:0] f);
    nz = (f == '0) ? FACTOR_ONE : f;
  endfunction : nz

  // Two engines in series: their factors multiply
  function automatic logic [PROD_W-1:0] chain(
    input logic [FACT_W-1:0] a,
    input logic [FACT_W-1:0] b
  );
    chain = PROD_W'(nz(a)) * PROD_W'(nz(b));
  endfunction : chain

  // Maps one output coordinate plus cell index to a sensor coordinate
  function automatic logic [DIM_W-1:0] src_coord(
    input logic [DIM_W-1:0]  off,
    input logic [DIM_W-1:0]  o,
    input logic [DIM_W-1:0]  max_dim,
    input logic              flip,
    input logic [PROD_W-1:0] step,
    input logic [PROD_W-1:0] k
  );
    logic [DIM_W-1:0] b;
    logic [DIM_W-1:0] f;
    b = off + o;
    // Offset plus size within the maximum is the controller's duty
    f = flip ? DIM_W'(max_dim - DIM_W'(1) - b) : b;
    src_coord = DIM_W'(f * DIM_W'(step)) + DIM_W'(k);
  endfunction : src_coord

  logic [PROD_W-1:0] bc, br, sc, sr;
  logic [DIM_W-1:0]  sx, sy;
  logic [ACC_W-1:0]  sum;
  logic [PIX_W-1:0]  sat;
  logic              last_c, last_r, last_px;
  logic              mosaic_out;

  always_comb begin
    s_nxt     = s_r;
    mem_we    = 1'b0;
    mem_waddr = s_r.wr_addr;
    bc = '0;
    br = '0;
    sc = '0;
    sr = '0;

    // Engine and layer registers take factors per selector
    if (bin_write) begin
      if (bin_sel) begin
        s_nxt.bin_c1 = col_bin_factor;
        s_nxt.bin_r1 = row_bin_factor;
      end else begin
        s_nxt.bin_c0 = col_bin_factor;
        s_nxt.bin_r0 = row_bin_factor;
      end
    end
    if (skip_write) begin
      if (skip_sel) begin
        s_nxt.skip_c1 = col_skip_factor;
        s_nxt.skip_r1 = row_skip_factor;
      end else begin
        s_nxt.skip_c0 = col_skip_factor;
        s_nxt.skip_r0 = row_skip_factor;
      end
    end

    // Geometry of the coming frame
    bc = chain(s_r.bin_c0, s_r.bin_c1);
    br = chain(s_r.bin_r0, s_r.bin_r1);
    sc = (bc == PROD_W'(1)) ? chain(s_r.skip_c0, s_r.skip_c1)
                            : PROD_W'(1);
    sr = (br == PROD_W'(1)) ? chain(s_r.skip_r0, s_r.skip_r1)
                            : PROD_W'(1);

    // Maximum dimensions ignore the ROI; shown for the live settings
    s_nxt.maxw = SW_C / DIM_W'(bc * sc);
    s_nxt.maxh = SH_C / DIM_W'(br * sr);

    // Core-only mono turns a mosaic into plain samples
    s_nxt.fmt = pixel_format;
    if (proc_core_enable && mono_request) begin
      s_nxt.fmt[FMT_MOSAIC_BIT] = 1'b0;
    end
    mosaic_out = s_nxt.fmt[FMT_MOSAIC_BIT];
    s_nxt.filt = FILTER_NONE;
    if (mosaic_out) begin
      s_nxt.filt = FILTER_SOME | {1'b0, MOSAIC_BASE
                   ^ {row_flip, col_flip}};
    end
    s_nxt.bits = s_nxt.fmt[FMT_DEEP_BIT] ? BITS_DEEP
                                         : BITS_SHALLOW;
    s_nxt.dmax = s_nxt.fmt[FMT_DEEP_BIT] ? DYN_MAX_16
                                         : DYN_MAX_8;

    // Source address of the current cell
    sx = src_coord(s_r.offx, s_r.ox, s_r.maxw, s_r.hflip,
                   s_r.step_c, s_r.kc);
    sy = src_coord(s_r.offy, s_r.oy, s_r.maxh, s_r.vflip,
                   s_r.step_r, s_r.kr);
    mem_raddr = ADDR_W'(sy * SENS_W) + ADDR_W'(sx);

    last_c  = (s_r.kc == s_r.cells_c - PROD_W'(1));
    last_r  = (s_r.kr == s_r.cells_r - PROD_W'(1));
    last_px = (s_r.ox == s_r.w - DIM_W'(1))
              && (s_r.oy == s_r.h - DIM_W'(1));
    sum = s_r.acc + ACC_W'(rd_q);
    // Additive binning saturates rather than wraps
    sat = (sum > ACC_W'(DYN_MAX_16)) ? DYN_MAX_16 : PIX_W'(sum);
    if (!s_r.fmt[FMT_DEEP_BIT]) begin
      sat = sat & SHALLOW_MASK;
    end

    // Two cycles per cell: address out, then registered read data
    unique case (s_r.state)
      ST_IDLE: begin
        if (in_valid && in_sof) begin
          // Flip, ROI and factors hold for a whole frame; format and maximum size stay live
          s_nxt.hflip   = col_flip;
          s_nxt.vflip   = row_flip;
          s_nxt.offx    = roi_col_offset;
          s_nxt.offy    = roi_row_offset;
          s_nxt.w       = roi_width;
          s_nxt.h       = roi_height;
          s_nxt.cells_c = bc;
          s_nxt.cells_r = br;
          // Decimation only strides; cells stay one, never averaged
          s_nxt.step_c  = PROD_W'(bc * sc);
          s_nxt.step_r  = PROD_W'(br * sr);
          mem_we        = 1'b1;
          mem_waddr     = '0;
          s_nxt.wr_addr = ADDR_W'(1);
          s_nxt.state   = ST_CAPT;
        end
      end
      ST_CAPT: begin
        if (in_valid) begin
          mem_we = 1'b1;
          if (in_sof) begin
            mem_waddr     = '0;
            s_nxt.wr_addr = ADDR_W'(1);
          end else begin
            s_nxt.wr_addr = s_r.wr_addr + ADDR_W'(1);
            if (s_r.wr_addr == LAST_ADDR) begin
              s_nxt.ox    = '0;
              s_nxt.oy    = '0;
              s_nxt.kc    = '0;
              s_nxt.kr    = '0;
              s_nxt.acc   = '0;
              s_nxt.state = ST_READ;
            end
          end
        end
      end
      ST_READ: begin
        s_nxt.state = ST_ACC;
      end
      ST_ACC: begin
        s_nxt.acc   = sum;
        s_nxt.state = ST_READ;
        if (last_c) begin
          s_nxt.kc = '0;
          if (last_r) begin
            s_nxt.kr      = '0;
            s_nxt.o_data  = sat;
            s_nxt.o_valid = 1'b1;
            s_nxt.o_sof   = (s_r.ox == '0) && (s_r.oy == '0);
            s_nxt.o_eol   = (s_r.ox == s_r.w - DIM_W'(1));
            s_nxt.o_eof   = last_px;
            s_nxt.state   = ST_SEND;
          end else begin
            s_nxt.kr = s_r.kr + PROD_W'(1);
          end
        end else begin
          s_nxt.kc = s_r.kc + PROD_W'(1);
        end
      end
      ST_SEND: begin
        if (out_ready) begin
          s_nxt.o_valid = 1'b0;
          s_nxt.acc     = '0;
          if (last_px) begin
            s_nxt.state = ST_IDLE;
          end else begin
            s_nxt.state = ST_READ;
            if (s_r.ox == s_r.w - DIM_W'(1)) begin
              s_nxt.ox = '0;
              s_nxt.oy = s_r.oy + DIM_W'(1);
            end else begin
              s_nxt.ox = s_r.ox + DIM_W'(1);
            end
          end
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.state   <= ST_IDLE;
      s_r.bin_c0  <= FACTOR_ONE;
      s_r.bin_c1  <= FACTOR_ONE;
      s_r.bin_r0  <= FACTOR_ONE;
      s_r.bin_r1  <= FACTOR_ONE;
      s_r.skip_c0 <= FACTOR_ONE;
      s_r.skip_c1 <= FACTOR_ONE;
      s_r.skip_r0 <= FACTOR_ONE;
      s_r.skip_r1 <= FACTOR_ONE;
      s_r.cells_c <= PROD_W'(1);
      s_r.cells_r <= PROD_W'(1);
      s_r.step_c  <= PROD_W'(1);
      s_r.step_r  <= PROD_W'(1);
      s_r.maxw    <= SW_C;
      s_r.maxh    <= SH_C;
      s_r.fmt     <= FMT_RESET;
      s_r.bits    <= BITS_SHALLOW;
      s_r.dmax    <= DYN_MAX_8;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Frame store has no reset; it is always filled before readout
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      frame_mem[mem_waddr] <= in_data;
    end
    rd_q <= frame_mem[mem_raddr];
  end

  // No back-pressure upstream: pixels arriving during readout are lost
  assign in_ready         = (s_r.state == ST_IDLE) || (s_r.state == ST_CAPT);
  assign out_valid        = s_r.o_valid;
  assign out_data         = s_r.o_data;
  assign out_sof          = s_r.o_sof;
  assign out_eol          = s_r.o_eol;
  assign out_eof          = s_r.o_eof;
  assign sensor_width     = SW_C;
  assign sensor_height    = SH_C;
  assign max_image_width  = s_r.maxw;
  assign max_image_height = s_r.maxh;
  assign reported_format  = s_r.fmt;
  assign pixel_filter     = s_r.filt;
  assign pixel_size_bits  = s_r.bits;
  assign dyn_range_min    = DYN_MIN;
  assign dyn_range_max    = s_r.dmax;

endmodule : image_geometry_pipeline
`default_nettype wire

// >>> verification/sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
module sensor_model #(
  parameter int W = 8,
  parameter int H = 6
) (
  input  wire logic        mclk,
  input  wire logic        start,
  input  wire logic        in_ready,
  output var  logic        in_valid,
  output var  logic        in_sof,
  output var  logic [15:0] in_data
);
  int cnt = -1;

  initial begin
    in_valid = 1'b0;
    in_sof = 1'b0;
    in_data = 16'h0000;
  end

  // Raster order; both bytes of a pixel hold its address
  always @(posedge mclk) begin
    if (cnt >= 0 && cnt < W * H && in_ready) begin
      in_valid <= 1'b1;
      in_sof <= (cnt == 0);
      in_data <= 16'(cnt * 257);
      cnt <= cnt + 1;
    end else begin
      in_valid <= 1'b0;
      in_sof <= 1'b0;
      // Idle bus inverts every cycle, so it shows the last pixel only every second idle cycle
      in_data <= ~in_data;
      if (start)
        cnt <= 0;
      else if (cnt == W * H)
        cnt <= -1;
    end
  end
endmodule : sensor_model
`default_nettype wire

// >>> verification/geom_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module geom_checker
  import geom_pkg::*;
#(
  parameter int         SENS_W      = SENSOR_W,
  parameter logic [1:0] MOSAIC_BASE = MOSAIC_RED_GREEN
) (
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             in_ready,
  input wire logic             out_valid,
  input wire logic             out_ready,
  input wire logic [PIX_W-1:0] out_data,
  input wire logic             out_eof,
  input wire logic             col_flip,
  input wire logic             row_flip,
  input wire logic [1:0]       pixel_format,
  input wire logic             proc_core_enable,
  input wire logic             mono_request,
  input wire logic [DIM_W-1:0] sensor_width,
  input wire logic [1:0]       reported_format,
  input wire logic [2:0]       pixel_filter,
  input wire logic [4:0]       pixel_size_bits,
  input wire logic [PIX_W-1:0] dyn_range_max
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic mono;
  assign mono = proc_core_enable & mono_request;

  a_width_const: assert property (
    sensor_width == DIM_W'(SENS_W)) else $error("sensor width wrong");
  a_filter_none: assert property (
    !pixel_format[FMT_MOSAIC_BIT] |=> pixel_filter == FILTER_NONE)
    else $error("filter reported for plain format");
  a_filter_phase: assert property (
    pixel_format[FMT_MOSAIC_BIT] && !mono |=> pixel_filter == (FILTER_SOME
      | {1'b0, MOSAIC_BASE ^ {$past(row_flip), $past(col_flip)}}))
    else $error("mosaic phase wrong");
  a_pixel_bits: assert property (
    1'b1 |=> pixel_size_bits == ($past(pixel_format[FMT_DEEP_BIT])
      ? BITS_DEEP : BITS_SHALLOW)) else $error("pixel size wrong");
  a_dyn_max: assert property (
    1'b1 |=> dyn_range_max == ($past(pixel_format[FMT_DEEP_BIT])
      ? DYN_MAX_16 : DYN_MAX_8)) else $error("dynamic range wrong");
  a_mono_core: assert property (
    1'b1 |=> reported_format == ($past(pixel_format)
      & {~$past(mono), 1'b1})) else $error("reported format wrong");
  a_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output pixel dropped before accept");
  a_no_back2back: assert property (
    out_valid && out_ready |=> !out_valid)
    else $error("output pixels back to back");
  a_eof_resume: assert property (
    out_valid && out_ready && out_eof |=> in_ready)
    else $error("capture not resumed after last pixel");
  a_readout_closed: assert property (
    out_valid |-> !in_ready) else $error("capture open during readout");
endmodule : geom_checker

bind image_geometry_pipeline geom_checker #(
  .SENS_W(SENS_W), .MOSAIC_BASE(MOSAIC_BASE)
) i_chk (
  .mclk(mclk), .rst_n(rst_n), .in_ready(in_ready), .out_valid(out_valid),
  .out_ready(out_ready), .out_data(out_data), .out_eof(out_eof),
  .col_flip(col_flip), .row_flip(row_flip), .pixel_format(pixel_format),
  .proc_core_enable(proc_core_enable), .mono_request(mono_request),
  .sensor_width(sensor_width), .reported_format(reported_format),
  .pixel_filter(pixel_filter), .pixel_size_bits(pixel_size_bits),
  .dyn_range_max(dyn_range_max)
);
`default_nettype wire

// >>> verification/image_geometry_pipeline_tb.sv
`timescale 1ns/100ps
`default_nettype none
module image_geometry_pipeline_tb;
  import geom_pkg::*;
  localparam int SW = 8;
  localparam int SH = 6;
  logic mclk = 0, rst_n = 0, start = 0, out_ready = 0;
  logic col_flip = 0, row_flip = 0, bin_sel = 0, bin_write = 0;
  logic skip_sel = 0, skip_write = 0, proc_core_enable = 0;
  logic mono_request = 0;
  logic [1:0] pixel_format = FMT_MOSAIC16;
  logic [FACT_W-1:0] col_bin_factor = 1, row_bin_factor = 1;
  logic [FACT_W-1:0] col_skip_factor = 1, row_skip_factor = 1;
  logic [DIM_W-1:0] roi_col_offset = 0, roi_row_offset = 0;
  logic [DIM_W-1:0] roi_width = 1, roi_height = 1;
  logic in_valid, in_sof, in_ready, out_valid, out_sof, out_eol, out_eof;
  logic [15:0] in_data, out_data, dyn_range_min, dyn_range_max;
  logic [DIM_W-1:0] sensor_width, sensor_height;
  logic [DIM_W-1:0] max_image_width, max_image_height;
  logic [1:0] reported_format;
  logic [2:0] pixel_filter;
  logic [4:0] pixel_size_bits;
  int num_errors = 0;
  int samples_checked = 0;

  always #25 mclk = ~mclk;
  // Host stalls every other cycle so outputs must hold
  always @(posedge mclk) out_ready <= ~out_ready;

  sensor_model #(.W(SW), .H(SH)) i_sensor (.mclk(mclk), .start(start),
    .in_ready(in_ready), .in_valid(in_valid), .in_sof(in_sof),
    .in_data(in_data));

  image_geometry_pipeline #(.SENS_W(SW), .SENS_H(SH)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .in_valid(in_valid), .in_sof(in_sof),
    .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_sof(out_sof),
    .out_eol(out_eol), .out_eof(out_eof), .col_flip(col_flip),
    .row_flip(row_flip), .roi_col_offset(roi_col_offset),
    .roi_row_offset(roi_row_offset), .roi_width(roi_width),
    .roi_height(roi_height), .pixel_format(pixel_format),
    .proc_core_enable(proc_core_enable), .mono_request(mono_request),
    .bin_sel(bin_sel), .bin_write(bin_write),
    .col_bin_factor(col_bin_factor), .row_bin_factor(row_bin_factor),
    .skip_sel(skip_sel), .skip_write(skip_write),
    .col_skip_factor(col_skip_factor), .row_skip_factor(row_skip_factor),
    .sensor_width(sensor_width), .sensor_height(sensor_height),
    .max_image_width(max_image_width), .max_image_height(max_image_height),
    .reported_format(reported_format), .pixel_filter(pixel_filter),
    .pixel_size_bits(pixel_size_bits), .dyn_range_min(dyn_range_min),
    .dyn_range_max(dyn_range_max));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  task automatic wr(input logic sel, input int bc, br, sc, sr);
    @(posedge mclk);
    bin_sel <= sel;
    skip_sel <= sel;
    bin_write <= 1'b1;
    skip_write <= 1'b1;
    col_bin_factor <= 3'(bc);
    row_bin_factor <= 3'(br);
    col_skip_factor <= 3'(sc);
    row_skip_factor <= 3'(sr);
    @(posedge mclk);
    bin_write <= 1'b0;
    skip_write <= 1'b0;
  endtask : wr

  task automatic scen(input int f, sel, bc, br, sc, sr, oc, ro, ww, hh);
    int mw, mh, bx, by, acc, t;
    logic [2:0] fl;
    wr(!sel, 1, 1, 1, 1);
    wr(sel, bc, br, sc, sr);
    @(posedge mclk);
    col_flip <= f[0];
    row_flip <= f[1];
    roi_col_offset <= 11'(oc);
    roi_row_offset <= 11'(ro);
    roi_width <= 11'(ww);
    roi_height <= 11'(hh);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    // Decimation yields to binning on the same axis
    if (bc != 1) sc = 1;
    if (br != 1) sr = 1;
    mw = SW / (bc * sc);
    mh = SH / (br * sr);
    settle(1);
    chk(16'(max_image_width), 16'(mw));
    chk(16'(max_image_height), 16'(mh));
    for (int y = 0; y < hh; y++) begin
      for (int x = 0; x < ww; x++) begin
        t = 0;
        do begin
          @(negedge mclk);
          t++;
        end while (!(out_valid === 1'b1 && out_ready === 1'b1) && t < 400);
        chk(16'(t < 400), 16'h0001);
        bx = oc + x;
        by = ro + y;
        if (f[0]) bx = mw - 1 - bx;
        if (f[1]) by = mh - 1 - by;
        acc = 0;
        for (int j = 0; j < br; j++)
          for (int k = 0; k < bc; k++)
            acc += ((by * br * sr + j) * SW + bx * bc * sc + k) * 257;
        // Sums saturate; shallow formats carry only the top byte
        if (acc > 32'hFFFF) acc = 32'hFFFF;
        if (!pixel_format[FMT_DEEP_BIT]) acc = acc & 32'hFF00;
        chk(out_data, 16'(acc));
        fl = {x == 0 && y == 0, x == ww - 1, x == ww - 1 && y == hh - 1};
        chk(16'({out_sof, out_eol, out_eof}), 16'(fl));
        @(posedge mclk);
      end
    end
  endtask : scen

  task automatic stop_test;
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    settle(1);
    chk(16'(sensor_width), 16'(SW));
    chk(16'(sensor_height), 16'(SH));
    chk(16'(max_image_width), 16'(SW));
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      pixel_format <= 2'(i);
      col_flip <= i[2];
      row_flip <= i[3];
      settle(1);
      chk(16'(pixel_filter), 16'(i[1] ? 4 + i / 4 : 0));
      chk(16'(pixel_size_bits), i[0] ? 16'h0010 : 16'h0008);
      chk(dyn_range_max, i[0] ? 16'hFFFF : 16'h00FF);
      chk(dyn_range_min, 16'h0000);
    end
    for (int j = 0; j < 4; j++) begin
      @(posedge mclk);
      proc_core_enable <= j[0];
      mono_request <= j[1];
      settle(1);
      chk(16'(reported_format), j == 3 ? 16'h0001 : 16'h0003);
      chk(16'(pixel_filter), j == 3 ? 16'h0000 : 16'h0007);
    end
    @(posedge mclk);
    proc_core_enable <= 1'b0;
    // Windows kept inside the image, as the controller must
    scen(0, 0, 1, 1, 1, 1, 1, 1, 3, 2);
    scen(1, 0, 1, 1, 1, 1, 1, 1, 3, 2);
    scen(2, 0, 1, 1, 1, 1, 2, 1, 3, 2);
    scen(3, 1, 2, 2, 1, 1, 1, 0, 2, 3);
    scen(0, 1, 1, 1, 2, 2, 0, 0, 4, 3);
    scen(1, 0, 2, 1, 3, 2, 0, 0, 4, 3);
    // Shallow format with twelve-cell bins, last pixel saturates
    @(posedge mclk);
    pixel_format <= FMT_MONO8;
    scen(0, 0, 4, 3, 1, 1, 0, 0, 2, 2);
    stop_test();
  end
endmodule : image_geometry_pipeline_tb
`default_nettype wire
